// File: src/radio_regs_pkg.sv
// Register map constants and carrier types for the radio register bank
package radio_regs_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W       = 6;
  localparam int DATA_W       = 8;
  localparam int BANK_DEPTH   = 64;
  localparam int A_COUNT_W    = 5;
  localparam int N_COUNT_W    = 7;
  localparam int CHAN_W       = 7;
  localparam int SYNTH_SUM_W  = 12;
  localparam int SPREAD_BYTES = 8;
  localparam int SERIAL_BYTES = 4;
  localparam int BIT_CNT_W    = 3;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_REVISION        = 6'h00;
  localparam logic [5:0] ADDR_SYNTH_A         = 6'h01;
  localparam logic [5:0] ADDR_SYNTH_N         = 6'h02;
  localparam logic [5:0] ADDR_SERIALIZER      = 6'h06;
  localparam logic [5:0] ADDR_RX_IRQ_EN       = 6'h07;
  localparam logic [5:0] ADDR_RX_IRQ_FLAGS    = 6'h08;
  localparam logic [5:0] ADDR_RX_BYTE_FIRST   = 6'h09;
  localparam logic [5:0] ADDR_RX_VALID_FIRST  = 6'h0a;
  localparam logic [5:0] ADDR_RX_BYTE_SECOND  = 6'h0b;
  localparam logic [5:0] ADDR_RX_VALID_SECOND = 6'h0c;
  localparam logic [5:0] ADDR_TX_IRQ_EN       = 6'h0d;
  localparam logic [5:0] ADDR_TX_IRQ_FLAGS    = 6'h0e;
  localparam logic [5:0] ADDR_TX_BYTE         = 6'h0f;
  localparam logic [5:0] ADDR_TX_BYTE_VALID   = 6'h10;
  localparam logic [5:0] ADDR_SPREAD_FIRST    = 6'h11;
  localparam logic [5:0] ADDR_SPREAD_LAST     = 6'h18;
  localparam logic [5:0] ADDR_THRESH_LOW      = 6'h19;
  localparam logic [5:0] ADDR_THRESH_HIGH     = 6'h1a;
  localparam logic [5:0] ADDR_WAKE_EN         = 6'h1c;
  localparam logic [5:0] ADDR_WAKE_FLAGS      = 6'h1d;
  localparam logic [5:0] ADDR_ANALOG          = 6'h20;
  localparam logic [5:0] ADDR_RF_FREQ         = 6'h21;
  localparam logic [5:0] ADDR_SIGNAL          = 6'h22;
  localparam logic [5:0] ADDR_AMP_POWER       = 6'h23;
  localparam logic [5:0] ADDR_CRYSTAL         = 6'h24;
  localparam logic [5:0] ADDR_OSC_CAL         = 6'h26;
  localparam logic [5:0] ADDR_GAIN_LOOP       = 6'h2e;
  localparam logic [5:0] ADDR_CARRIER         = 6'h2f;
  localparam logic [5:0] ADDR_CLOCK_OVERRIDE  = 6'h32;
  localparam logic [5:0] ADDR_CLOCK_GATE      = 6'h33;
  localparam logic [5:0] ADDR_SETTLE          = 6'h38;
  localparam logic [5:0] ADDR_SERIAL_FIRST    = 6'h3c;
  localparam logic [5:0] ADDR_SERIAL_LAST     = 6'h3f;

  // ---------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_ZERO        = 8'h00;
  localparam logic [7:0]  RST_SERIALIZER  = 8'h03;
  localparam logic [63:0] RST_SPREAD      = 64'h1e8b6a3de0e9b222;
  localparam logic [7:0]  RST_THRESH_LOW  = 8'h08;
  localparam logic [7:0]  RST_THRESH_HIGH = 8'h38;
  localparam logic [7:0]  RST_ANALOG      = 8'h04;
  localparam logic [7:0]  RST_SETTLE      = 8'h64;
  localparam int          CMD_DIR_BIT     = 7;
  localparam int          CMD_INC_BIT     = 6;
  localparam int          RF_MODE_BIT     = 7;
  localparam logic [6:0]  N_COUNT_MIN     = 7'h4a;
  localparam logic [6:0]  N_COUNT_MAX     = 7'h4c;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rx_irq_flags;
    logic [7:0] rx_byte_first;
    logic [7:0] rx_valid_first;
    logic [7:0] rx_byte_second;
    logic [7:0] rx_valid_second;
    logic [7:0] tx_irq_flags;
    logic [7:0] wake_irq_flags;
    logic [7:0] signal_strength;
  } radio_status_type;

  typedef struct packed {
    logic [7:0]  serializer_control;
    logic [7:0]  rx_irq_enable;
    logic [7:0]  tx_irq_enable;
    logic [7:0]  tx_byte;
    logic [7:0]  tx_byte_valid;
    logic [63:0] spreading_code;
    logic [7:0]  correlator_threshold_low;
    logic [7:0]  correlator_threshold_high;
    logic [7:0]  wake_irq_enable;
    logic [7:0]  analog_settings;
    logic [7:0]  rf_frequency_select;
    logic [7:0]  amplifier_power_level;
    logic [7:0]  crystal_trim;
    logic [7:0]  oscillator_calibration;
    logic [7:0]  gain_loop_control;
    logic [7:0]  carrier_sense;
    logic [7:0]  clock_override;
    logic [7:0]  synth_settle_count;
    logic [7:0]  clock_gate_enable;
    logic        synth_manual;
    logic [4:0]  synth_a_count;
    logic [6:0]  synth_n_count;
    logic        synth_counts_valid;
  } radio_config_type;

  typedef enum logic {
    CMD_PHASE  = 1'b0,
    DATA_PHASE = 1'b1
  } spi_phase_type;

endpackage

// File: src/serial_port_frontend.sv
// Four-wire serial port shifter: pin sync, byte assembly, read-data shift
`timescale 1ns/1ps
module serial_port_frontend
  import radio_regs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       spi_sck,
  input  wire logic       spi_mosi,
  input  wire logic       spi_ss_n,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  output logic            frame_idle,
  output logic            byte_valid,
  output logic [7:0]      rx_byte,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_data
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic                 sck_meta;
  logic                 sck_sync;
  logic                 sck_prev;
  logic                 mosi_meta;
  logic                 mosi_sync;
  logic                 ss_meta;
  logic                 ss_sync;
  logic                 sck_rise;
  logic                 sck_fall;
  logic [BIT_CNT_W-1:0] bit_count;
  logic [7:0]           shift_in;
  logic [7:0]           shift_out;
  logic [7:0]           tx_hold;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sck_meta  <= 1'b0;
      sck_sync  <= 1'b0;
      sck_prev  <= 1'b0;
      mosi_meta <= 1'b0;
      mosi_sync <= 1'b0;
      ss_meta   <= 1'b1;
      ss_sync   <= 1'b1;
    end else begin
      sck_meta  <= spi_sck;
      sck_sync  <= sck_meta;
      sck_prev  <= sck_sync;
      mosi_meta <= spi_mosi;
      mosi_sync <= mosi_meta;
      ss_meta   <= spi_ss_n;
      ss_sync   <= ss_meta;
    end
  end

  assign sck_rise   = sck_sync & ~sck_prev & ~ss_sync;
  assign sck_fall   = ~sck_sync & sck_prev & ~ss_sync;
  assign frame_idle = ss_sync;

  // ---------------------------------------------------------------
  // Byte assembly, MSB first, sampled on rising clock
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || ss_sync) begin
      bit_count  <= '0;
      shift_in   <= 8'h00;
      byte_valid <= 1'b0;
      rx_byte    <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (sck_rise) begin
        bit_count <= bit_count + 3'h1;
        shift_in  <= {shift_in[6:0], mosi_sync};
        if (bit_count == 3'h7) begin
          byte_valid <= 1'b1;
          rx_byte    <= {shift_in[6:0], mosi_sync};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data, changed on falling clock; loaded at byte boundary
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset || ss_sync) begin
      tx_hold   <= 8'h00;
      shift_out <= 8'h00;
    end else begin
      if (tx_load) begin
        tx_hold <= tx_data;
      end
      if (sck_fall) begin
        if (bit_count == 3'h0) begin
          shift_out <= tx_hold;
        end else begin
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  assign spi_miso    = shift_out[7];
  assign spi_miso_oe = ~ss_sync;

endmodule // serial_port_frontend

// File: src/radio_register_map.sv
// Register bank of the radio transceiver behind the four-wire serial port
`timescale 1ns/1ps

// Overview of operation
// - Multi-address registers are little-endian, least significant byte lowest.
// - Revision bits 7:4 are read-only silicon revision, counting up from zero.
// - Revision bits 3:0 are read-only and return a fixed product code.
// - A count lives in bits 4:0, values 0 to 31.
// - Frequency register bit 7 selects channel tuning or manual A and N.
// - In channel tuning, A and N reads return counts derived from channel.
// - N count lives in bits 6:0, bit 7 reserved; valid 74 to 76.
module radio_register_map
  import radio_regs_pkg::*;
#(
  // Arbitrary neutral values, set per build
  parameter logic [3:0]  SILICON_REVISION = 4'h0,
  parameter logic [3:0]  PRODUCT_CODE     = 4'h5,
  parameter logic [31:0] FACTORY_SERIAL   = 32'h0000_0000,
  // Synthesizer total count for channel zero
  parameter logic [11:0] SYNTH_BASE_COUNT = 12'h944
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             spi_sck,
  input  wire logic             spi_mosi,
  input  wire logic             spi_ss_n,
  output logic                  spi_miso,
  output logic                  spi_miso_oe,
  input  wire radio_status_type radio_status,
  output radio_config_type      radio_config
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]      bank [0:BANK_DEPTH-1];
  logic                   frame_idle;
  logic                   byte_valid;
  logic [7:0]             rx_byte;
  logic                   tx_load;
  logic [7:0]             tx_data;
  spi_phase_type          phase;
  logic                   cmd_write;
  logic                   cmd_inc;
  logic [ADDR_W-1:0]      cur_addr;
  logic [ADDR_W-1:0]      addr_sel;
  logic                   reading;
  logic                   write_strobe;
  logic [ADDR_W-1:0]      wr_addr;
  logic [7:0]             wr_data;
  logic [7:0]             wr_old;
  logic [7:0]             read_data;
  logic [7:0]             chan_reg;
  logic [7:0]             a_reg;
  logic [7:0]             n_reg;
  logic                   manual_mode;
  logic [SYNTH_SUM_W-1:0] synth_sum;
  logic [A_COUNT_W-1:0]   derived_a;
  logic [N_COUNT_W-1:0]   derived_n;
  logic [A_COUNT_W-1:0]   eff_a;
  logic [N_COUNT_W-1:0]   eff_n;
  radio_config_type       next_config;

  // ---------------------------------------------------------------
  // Serial port front end
  // ---------------------------------------------------------------
  serial_port_frontend u_frontend (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .spi_sck     (spi_sck),
    .spi_mosi    (spi_mosi),
    .spi_ss_n    (spi_ss_n),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .frame_idle  (frame_idle),
    .byte_valid  (byte_valid),
    .rx_byte     (rx_byte),
    .tx_load     (tx_load),
    .tx_data     (tx_data)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_writable(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_SYNTH_A, ADDR_SYNTH_N, ADDR_SERIALIZER, ADDR_RX_IRQ_EN,
      ADDR_TX_IRQ_EN, ADDR_TX_BYTE, ADDR_TX_BYTE_VALID,
      ADDR_THRESH_LOW, ADDR_THRESH_HIGH, ADDR_WAKE_EN, ADDR_ANALOG,
      ADDR_RF_FREQ, ADDR_AMP_POWER, ADDR_CRYSTAL, ADDR_OSC_CAL,
      ADDR_GAIN_LOOP, ADDR_CARRIER, ADDR_CLOCK_OVERRIDE,
      ADDR_CLOCK_GATE, ADDR_SETTLE:
        is_writable = 1'b1;
      default:
        is_writable = (a >= ADDR_SPREAD_FIRST) && (a <= ADDR_SPREAD_LAST);
    endcase
  endfunction

  function automatic logic [7:0] reset_value(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] k;
    k = a - ADDR_SPREAD_FIRST;
    unique case (a)
      ADDR_SERIALIZER:  reset_value = RST_SERIALIZER;
      ADDR_THRESH_LOW:  reset_value = RST_THRESH_LOW;
      ADDR_THRESH_HIGH: reset_value = RST_THRESH_HIGH;
      ADDR_ANALOG:      reset_value = RST_ANALOG;
      ADDR_SETTLE:      reset_value = RST_SETTLE;
      default: begin
        if ((a >= ADDR_SPREAD_FIRST) && (a <= ADDR_SPREAD_LAST)) begin
          reset_value = RST_SPREAD[k[2:0]*8 +: 8];
        end else begin
          reset_value = RST_ZERO;
        end
      end
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Synthesizer counts
  // ---------------------------------------------------------------
  assign chan_reg    = bank[ADDR_RF_FREQ];
  assign a_reg       = bank[ADDR_SYNTH_A];
  assign n_reg       = bank[ADDR_SYNTH_N];
  assign manual_mode = chan_reg[RF_MODE_BIT];
  assign synth_sum   = SYNTH_BASE_COUNT
                     + {{(SYNTH_SUM_W-CHAN_W){1'b0}}, chan_reg[CHAN_W-1:0]};
  assign derived_a   = synth_sum[A_COUNT_W-1:0];
  assign derived_n   = synth_sum[A_COUNT_W +: N_COUNT_W];
  assign eff_a = manual_mode ? a_reg[A_COUNT_W-1:0] : derived_a;
  assign eff_n = manual_mode ? n_reg[N_COUNT_W-1:0] : derived_n;

  // ---------------------------------------------------------------
  // Transaction tracking
  // ---------------------------------------------------------------
  always_comb begin
    if (phase == CMD_PHASE) begin
      addr_sel = rx_byte[ADDR_W-1:0];
      reading  = ~rx_byte[CMD_DIR_BIT];
    end else begin
      addr_sel = cmd_inc ? cur_addr + 6'h01 : cur_addr;
      reading  = ~cmd_write;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || frame_idle) begin
      phase     <= CMD_PHASE;
      cmd_write <= 1'b0;
      cmd_inc   <= 1'b0;
      cur_addr  <= '0;
    end else if (byte_valid) begin
      phase    <= DATA_PHASE;
      cur_addr <= addr_sel;
      if (phase == CMD_PHASE) begin
        cmd_write <= rx_byte[CMD_DIR_BIT];
        cmd_inc   <= rx_byte[CMD_INC_BIT];
      end
    end
  end

  assign write_strobe = byte_valid && (phase == DATA_PHASE) && cmd_write;
  assign wr_addr      = cur_addr;
  assign wr_data      = rx_byte;
  assign wr_old       = bank[wr_addr];

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  // Read-only and unmapped addresses never enter the bank
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < BANK_DEPTH; i++) begin
        bank[i] <= reset_value(ADDR_W'(i));
      end
    end else if (write_strobe && is_writable(wr_addr)) begin
      unique case (wr_addr)
        ADDR_SYNTH_A:
          bank[wr_addr] <= {3'h0, wr_data[A_COUNT_W-1:0]};
        ADDR_SYNTH_N:
          bank[wr_addr] <= {1'h0, wr_data[N_COUNT_W-1:0]};
        default:
          bank[wr_addr] <= wr_data;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  always_comb begin
    logic [ADDR_W-1:0] k;
    k = addr_sel - ADDR_SERIAL_FIRST;
    unique case (addr_sel)
      ADDR_REVISION:
        read_data = {SILICON_REVISION, PRODUCT_CODE};
      ADDR_SYNTH_A:        read_data = {3'h0, eff_a};
      ADDR_SYNTH_N:        read_data = {1'h0, eff_n};
      ADDR_RX_IRQ_FLAGS:   read_data = radio_status.rx_irq_flags;
      ADDR_RX_BYTE_FIRST:  read_data = radio_status.rx_byte_first;
      ADDR_RX_VALID_FIRST: read_data = radio_status.rx_valid_first;
      ADDR_RX_BYTE_SECOND: read_data = radio_status.rx_byte_second;
      ADDR_RX_VALID_SECOND:read_data = radio_status.rx_valid_second;
      ADDR_TX_IRQ_FLAGS:   read_data = radio_status.tx_irq_flags;
      ADDR_WAKE_FLAGS:     read_data = radio_status.wake_irq_flags;
      ADDR_SIGNAL:         read_data = radio_status.signal_strength;
      default: begin
        if (addr_sel >= ADDR_SERIAL_FIRST) begin
          read_data = FACTORY_SERIAL[k[1:0]*8 +: 8];
        end else if (is_writable(addr_sel)) begin
          read_data = bank[addr_sel];
        end else begin
          read_data = RST_ZERO;
        end
      end
    endcase
  end

  // Registered so the front end sees stable data well before the edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_load <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      tx_load <= byte_valid && reading;
      if (byte_valid && reading) begin
        tx_data <= read_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  always_comb begin
    next_config                           = '0;
    next_config.serializer_control        = bank[ADDR_SERIALIZER];
    next_config.rx_irq_enable             = bank[ADDR_RX_IRQ_EN];
    next_config.tx_irq_enable             = bank[ADDR_TX_IRQ_EN];
    next_config.tx_byte                   = bank[ADDR_TX_BYTE];
    next_config.tx_byte_valid             = bank[ADDR_TX_BYTE_VALID];
    for (int b = 0; b < SPREAD_BYTES; b++) begin
      next_config.spreading_code[b*8 +: 8] =
        bank[ADDR_SPREAD_FIRST + ADDR_W'(b)];
    end
    next_config.correlator_threshold_low  = bank[ADDR_THRESH_LOW];
    next_config.correlator_threshold_high = bank[ADDR_THRESH_HIGH];
    next_config.wake_irq_enable           = bank[ADDR_WAKE_EN];
    next_config.analog_settings           = bank[ADDR_ANALOG];
    next_config.rf_frequency_select       = chan_reg;
    next_config.amplifier_power_level     = bank[ADDR_AMP_POWER];
    next_config.crystal_trim              = bank[ADDR_CRYSTAL];
    next_config.oscillator_calibration    = bank[ADDR_OSC_CAL];
    next_config.gain_loop_control         = bank[ADDR_GAIN_LOOP];
    next_config.carrier_sense             = bank[ADDR_CARRIER];
    next_config.clock_override            = bank[ADDR_CLOCK_OVERRIDE];
    next_config.synth_settle_count        = bank[ADDR_SETTLE];
    next_config.clock_gate_enable         = bank[ADDR_CLOCK_GATE];
    next_config.synth_manual              = manual_mode;
    next_config.synth_a_count             = eff_a;
    next_config.synth_n_count             = eff_n;
    // Out-of-range N is flagged rather than clamped
    next_config.synth_counts_valid = (eff_n >= N_COUNT_MIN)
                                  && (eff_n <= N_COUNT_MAX);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      radio_config <= '0;
    end else begin
      radio_config <= next_config;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_revision_fixed: assert property (
    @(posedge sys_clk) disable iff (reset)
    (byte_valid && reading && addr_sel == ADDR_REVISION)
      |=> tx_load && tx_data == {SILICON_REVISION, PRODUCT_CODE})
    else $error("revision read returned wrong value");

  a_product_code: assert property (
    @(posedge sys_clk) disable iff (reset)
    (tx_load && $past(addr_sel) == ADDR_REVISION && $past(reading))
      |-> tx_data[3:0] == PRODUCT_CODE)
    else $error("product code changed");

  a_ro_write_ignored: assert property (
    @(posedge sys_clk) disable iff (reset)
    (write_strobe && !is_writable(wr_addr))
      |=> bank[$past(wr_addr)] == $past(wr_old))
    else $error("write to read-only address changed state");

  a_a_count_store: assert property (
    @(posedge sys_clk) disable iff (reset)
    (write_strobe && wr_addr == ADDR_SYNTH_A)
      |=> a_reg == {3'h0, $past(wr_data[4:0])})
    else $error("A count not stored in bits 4:0");

  a_n_count_store: assert property (
    @(posedge sys_clk) disable iff (reset)
    (write_strobe && wr_addr == ADDR_SYNTH_N)
      |=> n_reg == {1'h0, $past(wr_data[6:0])})
    else $error("N count not stored in bits 6:0");

  a_mode_select: assert property (
    @(posedge sys_clk) disable iff (reset)
    $past(manual_mode)
      |-> radio_config.synth_a_count == $past(a_reg[4:0])
       && radio_config.synth_n_count == $past(n_reg[6:0]))
    else $error("manual mode does not use stored counts");

  a_derived_read: assert property (
    @(posedge sys_clk) disable iff (reset)
    (byte_valid && reading && addr_sel == ADDR_SYNTH_A && !manual_mode)
      |=> tx_data == {3'h0, $past(derived_a)})
    else $error("A read in channel mode not derived");

  a_derived_n_read: assert property (
    @(posedge sys_clk) disable iff (reset)
    (byte_valid && reading && addr_sel == ADDR_SYNTH_N && !manual_mode)
      |=> tx_data == {1'h0, $past(derived_n)})
    else $error("N read in channel mode not derived");

  a_channel_mode: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!$past(manual_mode) && !$past(reset))
      |-> radio_config.synth_a_count == $past(derived_a)
       && radio_config.synth_n_count == $past(derived_n))
    else $error("channel mode does not use derived counts");

  a_a_count_range: assert property (
    @(posedge sys_clk) disable iff (reset)
    a_reg[7:A_COUNT_W] == 3'h0)
    else $error("A count reserved bits not zero");

  a_spread_order: assert property (
    @(posedge sys_clk) disable iff (reset)
    (write_strobe && wr_addr == ADDR_SPREAD_FIRST)
      ##1 1'b1 |=> radio_config.spreading_code[7:0] == $past(wr_data, 2))
    else $error("lowest spreading address is not the low byte");

endmodule // radio_register_map

// File: bench/spi_host_model.sv
// Host microcontroller model driving the four-wire serial port
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       sys_clk,
  input  wire logic       miso,
  output logic            sck,
  output logic            mosi,
  output logic            ss_n,
  output logic [7:0]      rd_data,
  output logic            rd_done
);
  initial begin
    sck = 0; mosi = 0; ss_n = 1; rd_data = 0; rd_done = 0;
  end
  // Mode 0, sck high for 8 clocks and low for 16 keeps twice the sync margin
  task automatic frame(input logic [23:0] sh, input int nb);
    int i;
    @(negedge sys_clk) ss_n = 0;
    for (i = nb - 1; i >= 0; i--) begin
      repeat (8) @(negedge sys_clk);
      mosi = sh[i];
      repeat (8) @(negedge sys_clk);
      sck = 1;
      rd_data = {rd_data[6:0], miso};
      repeat (8) @(negedge sys_clk);
      sck = 0;
    end
    repeat (8) @(negedge sys_clk);
    ss_n = 1;
    mosi = ~mosi;
    rd_done = ~sh[nb-1];
    @(negedge sys_clk) rd_done = 0;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule // spi_host_model

// File: bench/radio_register_map_tb_top.sv
// Self-checking bench for the radio register bank
`timescale 1ns/1ps
module radio_register_map_tb_top;
  import radio_regs_pkg::*;
  logic             sys_clk = 0;
  logic             reset = 1;
  logic             sck, mosi, ss_n, miso, miso_oe, miso_line, rd_done;
  logic [7:0]       rd_data, v, last;
  logic [11:0]      t;
  logic [31:0]      seed = 32'h2c;
  int               err_count = 0, cmp_count = 0, cycles = 0, i;
  logic [7:0]       exp_q[$];
  radio_status_type radio_status;
  radio_config_type radio_config;
  logic [5:0] rw_addr[19] = '{6'h06, 6'h07, 6'h0d, 6'h0f, 6'h10, 6'h11,
    6'h18, 6'h19, 6'h1a, 6'h1c, 6'h20, 6'h23, 6'h24, 6'h26, 6'h2e, 6'h2f,
    6'h32, 6'h33, 6'h38};

  always #2 sys_clk = ~sys_clk;
  // Released line toggles so a stale bit never reads as data
  assign miso_line = miso_oe ? miso : cycles[0];

  // Identity values are arbitrary
  radio_register_map #(.SILICON_REVISION(4'h1), .PRODUCT_CODE(4'h9))
    u_radio_register_map (.sys_clk(sys_clk), .reset(reset), .spi_sck(sck),
    .spi_mosi(mosi), .spi_ss_n(ss_n), .spi_miso(miso),
    .spi_miso_oe(miso_oe), .radio_status(radio_status),
    .radio_config(radio_config));
  spi_host_model u_spi_host_model (.sys_clk(sys_clk), .miso(miso_line),
    .sck(sck), .mosi(mosi), .ss_n(ss_n), .rd_data(rd_data),
    .rd_done(rd_done));

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_spi_host_model.frame({8'h00, 2'b10, a, d}, 16);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_spi_host_model.frame({8'h00, 2'b00, a, 8'h00}, 16);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Read-back watcher
  // -------------------------------------------------------------
  always @(posedge rd_done) begin
    check(rd_data, exp_q.pop_front());
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    radio_status = {xs(), xs(), xs(), xs(), xs(), xs(), xs(), xs()};
    repeat (3) @(negedge sys_clk);
    reset = 0;
    rd(ADDR_REVISION, 8'h19);
    rd(ADDR_SERIALIZER, RST_SERIALIZER);
    for (i = 0; i < 8; i++) rd(6'(ADDR_SPREAD_FIRST + i), RST_SPREAD[8*i+:8]);
    rd(ADDR_THRESH_LOW, RST_THRESH_LOW);
    rd(ADDR_THRESH_HIGH, RST_THRESH_HIGH);
    rd(ADDR_ANALOG, RST_ANALOG);
    rd(ADDR_SETTLE, RST_SETTLE);
    rd(ADDR_SYNTH_A, 8'h04);
    rd(ADDR_SYNTH_N, 8'h4a);
    rd(6'h03, 8'h00);
    wr(ADDR_REVISION, xs());
    rd(ADDR_REVISION, 8'h19);
    wr(ADDR_RX_IRQ_FLAGS, ~radio_status.rx_irq_flags);
    rd(ADDR_RX_IRQ_FLAGS, radio_status.rx_irq_flags);
    foreach (rw_addr[k]) begin
      v = xs();
      if (rw_addr[k] == ADDR_SPREAD_LAST) last = v;
      wr(rw_addr[k], v);
      rd(rw_addr[k], v);
    end
    check(radio_config.spreading_code[63:56], last);
    // Two-byte bursts with auto-increment, written then read back
    v = xs();
    last = xs();
    u_spi_host_model.frame({2'b11, ADDR_SPREAD_FIRST, v, last}, 24);
    check(radio_config.spreading_code[7:0], v);
    check(radio_config.spreading_code[15:8], last);
    exp_q.push_back(last);
    u_spi_host_model.frame({2'b01, ADDR_SPREAD_FIRST, 16'h0000}, 24);
    for (i = 0; i < 3; i++) begin
      v = xs() & 8'h7f;
      wr(ADDR_RF_FREQ, v);
      t = 12'h944 + {5'h00, v[6:0]};
      rd(ADDR_SYNTH_A, {3'h0, t[4:0]});
      rd(ADDR_SYNTH_N, {1'b0, t[11:5]});
      check({7'h00, radio_config.synth_manual}, 8'h00);
      check(radio_config.rf_frequency_select, v);
    end
    // Manual counts drive the synthesizer outputs, reserved bits kept zero
    wr(ADDR_RF_FREQ, 8'h80);
    wr(ADDR_SYNTH_A, 8'h1f);
    wr(ADDR_SYNTH_N, 8'h4b);
    rd(ADDR_SYNTH_A, 8'h1f);
    rd(ADDR_SYNTH_N, 8'h4b);
    check({3'h0, radio_config.synth_a_count}, 8'h1f);
    check({7'h00, radio_config.synth_counts_valid}, 8'h01);
    // Channel 7f derives an N of 78, outside the valid range
    wr(ADDR_RF_FREQ, 8'h7f);
    check({7'h00, radio_config.synth_counts_valid}, 8'h00);
    end_of_test();
  end
endmodule // radio_register_map_tb_top
